// *** rtl/rxlsb_bank.sv ***
// Receive latched status register bank with AHB-Lite slave
//
// Local design decision: register access over AHB-Lite.
module rxlsb_bank #(
    parameter int SEC_T1 = rxlsb_pkg::SEC_T1_EDGES,
    parameter int SEC_E1 = rxlsb_pkg::SEC_E1_EDGES,
    parameter int SHT_T1 = rxlsb_pkg::SHT_T1_EDGES,
    parameter int SHT_E1 = rxlsb_pkg::SHT_E1_EDGES
) (
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    input  wire logic                   recoveredRxClock,
    input  wire rxlsb_pkg::rxlsb_level_s detLevel,
    input  wire rxlsb_pkg::rxlsb_event_s detEvent,
    output logic                        rxIrqReq
);

    localparam int CNT_W_L = rxlsb_pkg::CNT_W;

    // Bus state
    logic        wrPend_reg,  wrPend_next;
    logic [11:0] wrIdx_reg,   wrIdx_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic        ready_reg;
    logic        resp_reg;

    // Software registers
    logic [31:0] config_reg,  config_next;
    logic [15:0] spareDef_reg, spareDef_next;
    logic [15:0] loopDnDef_reg, loopDnDef_next;
    logic [31:0] sigEn_reg,   sigEn_next;
    logic [31:0] mask_reg,    mask_next;
    logic        manual_reg,  manual_next;

    // Status
    logic [7:0]  stat3_reg,   stat3_next;
    logic [7:0]  stat4_reg,   stat4_next;
    logic [7:0]  hdlc_reg,    hdlc_next;
    logic [7:0]  stat7_reg,   stat7_next;
    logic [7:0]  info_reg,    info_next;
    logic        irq_reg,     irq_next;

    // Condition history for edge detection
    logic [8:0]  prev_reg,    prev_next;
    logic        spareM_reg,  spareM_next;
    logic        loopDnM_reg, loopDnM_next;
    logic [1:0]  rdmaCnt_reg, rdmaCnt_next;

    // Recovered clock sampling and timers
    logic [2:0]  rxSync_reg,  rxSync_next;
    logic        rxLvl_reg,   rxLvl_next;
    logic [8:0]  lorcCnt_reg, lorcCnt_next;
    logic [CNT_W_L-1:0] secCnt_reg, secCnt_next;
    logic [CNT_W_L-1:0] tmrCnt_reg, tmrCnt_next;
    logic [12:0] mfCnt_reg,   mfCnt_next;

    logic        accept;
    logic        rxRise;
    logic        rdClrHdlc;
    logic        rdClrStat7;
    logic        e1;
    logic        rxEdge;
    logic        rx_clock_loss_condition;
    logic        secTick;
    logic        tmrTick;
    logic        mfTick;
    logic        rdma;
    logic        wmLvl;
    logic        neLvl;
    logic [8:0]  cond;
    logic [8:0]  rise;
    logic [8:0]  fall;
    logic [7:0]  set3, set4, set5, set7;
    logic [7:0]  clr3, clr4;
    logic [31:0] rdValue;
    logic [CNT_W_L-1:0] secLim, tmrLim;
    logic [8:0]  lorcLim;

    assign e1 = config_reg[rxlsb_pkg::CFG_E1];

    // Timers and detectors
    always_comb begin
        // A clock change counts only once the later two stages agree
        rxSync_next = {rxSync_reg[1:0], recoveredRxClock};
        rxEdge      = (rxSync_reg[1] == rxSync_reg[2]) && (rxSync_reg[2] != rxLvl_reg);
        rxLvl_next  = rxEdge ? rxSync_reg[2] : rxLvl_reg;
        // Intervals count rising edges only, one per line clock period
        rxRise      = rxEdge && rxSync_reg[2];

        lorcLim = e1 ? 9'(rxlsb_pkg::RX_CLOCK_LOSS_CONDITION_E1_CYC) : 9'(rxlsb_pkg::RX_CLOCK_LOSS_CONDITION_T1_CYC);
        rx_clock_loss_condition    = lorcCnt_reg >= lorcLim;
        lorcCnt_next = rxEdge ? 9'h000 : (rx_clock_loss_condition ? lorcCnt_reg : lorcCnt_reg + 9'h001);

        secLim  = e1 ? CNT_W_L'(SEC_E1) : CNT_W_L'(SEC_T1);
        secTick = rxRise && (secCnt_reg == secLim - CNT_W_L'(1));
        secCnt_next = rxRise ? (secTick ? '0 : secCnt_reg + CNT_W_L'(1)) : secCnt_reg;

        // Short interval picked by the counter configuration bit
        if (config_reg[rxlsb_pkg::CFG_SHORT]) begin
            tmrLim = e1 ? CNT_W_L'(SHT_E1) : CNT_W_L'(SHT_T1);
        end else begin
            tmrLim = secLim;
        end
        tmrTick = (rxRise && (tmrCnt_reg >= tmrLim - CNT_W_L'(1))) || manual_reg;
        if (rxRise) begin
            tmrCnt_next = (tmrCnt_reg >= tmrLim - CNT_W_L'(1)) ? '0 : tmrCnt_reg + CNT_W_L'(1);
        end else begin
            tmrCnt_next = tmrCnt_reg;
        end

        // Without CAS the E1 multiframe flag runs on a free 2ms boundary
        if (rxRise) begin
            mfCnt_next = (mfCnt_reg == 13'(rxlsb_pkg::MF_E1_EDGES - 1)) ? 13'h0000
                                                                        : mfCnt_reg + 13'h0001;
        end else begin
            mfCnt_next = mfCnt_reg;
        end
        if (e1 && !config_reg[rxlsb_pkg::CFG_CAS]) begin
            mfTick = rxRise && (mfCnt_reg == 13'(rxlsb_pkg::MF_E1_EDGES - 1));
        end else begin
            mfTick = detEvent.mfBoundary;
        end

        spareM_next  = detLevel.codeValid && (detLevel.codeWord == spareDef_reg);
        loopDnM_next = detLevel.codeValid && (detLevel.codeWord == loopDnDef_reg);

        // Two multiframes in a row with the alarm bit set
        if (detEvent.mfAlarmStrobe) begin
            if (detEvent.mfAlarmBit) begin
                rdmaCnt_next = (rdmaCnt_reg == 2'h2) ? 2'h2 : rdmaCnt_reg + 2'h1;
            end else begin
                rdmaCnt_next = 2'h0;
            end
        end else begin
            rdmaCnt_next = rdmaCnt_reg;
        end
        rdma = rdmaCnt_reg == 2'h2;

        wmLvl = detLevel.hdlcFill >
                {1'b0, config_reg[rxlsb_pkg::CFG_WM_LSB +: rxlsb_pkg::WM_W]};
        neLvl = detLevel.hdlcFill != 7'h00;

        cond = {neLvl, wmLvl, detLevel.bocValid, rdma, detLevel.v52Link,
                detLevel.loopUp, loopDnM_reg, spareM_reg, rx_clock_loss_condition};
        prev_next = cond;
        rise = cond & ~prev_reg;
        fall = ~cond & prev_reg;
    end

    // Bus decode and register writes
    always_comb begin
        accept      = hsel && htrans[1] && hready;
        wrPend_next = accept && hwrite;
        wrIdx_next  = accept ? haddr[13:2] : wrIdx_reg;

        unique case (haddr[13:2])
            rxlsb_pkg::IDX_STAT3:      rdValue = {24'h000000, stat3_reg};
            rxlsb_pkg::IDX_STAT4:      rdValue = {24'h000000, stat4_reg};
            rxlsb_pkg::IDX_HDLC:       rdValue = {24'h000000, hdlc_reg};
            rxlsb_pkg::IDX_STAT7:      rdValue = {24'h000000, stat7_reg};
            rxlsb_pkg::IDX_INFO:       rdValue = {24'h000000, info_reg};
            rxlsb_pkg::IDX_CONFIG:     rdValue = config_reg;
            rxlsb_pkg::IDX_SPARE_DEF:  rdValue = {16'h0000, spareDef_reg};
            rxlsb_pkg::IDX_LOOPDN_DEF: rdValue = {16'h0000, loopDnDef_reg};
            rxlsb_pkg::IDX_SIG_EN:     rdValue = sigEn_reg;
            rxlsb_pkg::IDX_MASK:       rdValue = mask_reg;
            default:                   rdValue = 32'h0000_0000;
        endcase
        rdata_next = (accept && !hwrite) ? rdValue : rdata_reg;
        rdClrHdlc  = accept && !hwrite && (haddr[13:2] == rxlsb_pkg::IDX_HDLC);
        rdClrStat7 = accept && !hwrite && (haddr[13:2] == rxlsb_pkg::IDX_STAT7);

        config_next    = config_reg;
        spareDef_next  = spareDef_reg;
        loopDnDef_next = loopDnDef_reg;
        sigEn_next     = sigEn_reg;
        mask_next      = mask_reg;
        manual_next    = 1'b0;
        clr3           = 8'h00;
        clr4           = 8'h00;
        if (wrPend_reg) begin
            unique case (wrIdx_reg)
                rxlsb_pkg::IDX_STAT3:      clr3 = hwdata[7:0];
                rxlsb_pkg::IDX_STAT4:      clr4 = hwdata[7:0];
                rxlsb_pkg::IDX_CONFIG: begin
                    // Manual latch is a strobe and is never stored
                    config_next = hwdata & 32'h0000_3F0F;
                    manual_next = hwdata[rxlsb_pkg::CFG_MANUAL];
                end
                rxlsb_pkg::IDX_SPARE_DEF:  spareDef_next  = hwdata[15:0];
                rxlsb_pkg::IDX_LOOPDN_DEF: loopDnDef_next = hwdata[15:0];
                rxlsb_pkg::IDX_SIG_EN:     sigEn_next     = hwdata;
                rxlsb_pkg::IDX_MASK:       mask_next      = hwdata;
                default:                   clr3           = 8'h00;
            endcase
        end
    end

    // Status capture; a new event in a clearing cycle survives
    always_comb begin
        if (e1) begin
            set3 = {fall[0], 1'b0, fall[4], fall[5], rise[0], 1'b0, rise[4], rise[5]};
        end else begin
            set3 = {fall[0], fall[1], fall[2], fall[3],
                    rise[0], rise[1], rise[2], rise[3]};
        end
        set3[7] = fall[0];
        set3[3] = rise[0];

        set4 = {detEvent.elasticFull,
                detEvent.elasticEmpty,
                detEvent.elasticFull || detEvent.elasticEmpty,
                1'b0,
                |(detEvent.sigChange & sigEn_reg),
                secTick, tmrTick, mfTick};

        set5 = {2'b00,
                detEvent.hdlcOverrun,
                detEvent.hdlcOpeningNext,
                detEvent.hdlcPacketEnd,
                detEvent.hdlcPacketStart,
                rise[7],
                rise[8]};

        set7 = 8'h00;
        if (!e1) begin
            set7[5] = config_reg[rxlsb_pkg::CFG_ESF] && detLevel.raiActive
                      && detEvent.raiCiPattern;
            set7[4] = detLevel.aisActive && detEvent.aisCiPattern;
            set7[3] = detEvent.slcAlign;
            set7[2] = detEvent.dataLinkFull;
            set7[1] = fall[6];
            set7[0] = rise[6];
        end

        stat3_next = (stat3_reg & ~clr3) | set3;
        stat4_next = (stat4_reg & ~clr4) | set4;
        hdlc_next  = (rdClrHdlc ? 8'h00 : hdlc_reg) | set5;
        stat7_next = (rdClrStat7 ? 8'h00 : stat7_reg) | set7;

        info_next = 8'h00;
        info_next[rxlsb_pkg::INFO_STAT3] = |(stat3_reg & mask_reg[rxlsb_pkg::MASK_STAT3 +: 8]);
        info_next[rxlsb_pkg::INFO_STAT4] = |(stat4_reg & mask_reg[rxlsb_pkg::MASK_STAT4 +: 8]);
        info_next[rxlsb_pkg::INFO_HDLC]  = |(hdlc_reg & mask_reg[rxlsb_pkg::MASK_HDLC +: 8]);
        info_next[rxlsb_pkg::INFO_STAT7] = |(stat7_reg & mask_reg[rxlsb_pkg::MASK_STAT7 +: 8]);
        irq_next = |info_next;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wrPend_reg    <= 1'b0;
            wrIdx_reg     <= 12'h000;
            rdata_reg     <= rxlsb_pkg::WORD_RESET;
            ready_reg     <= 1'b1;
            resp_reg      <= 1'b0;
            config_reg    <= rxlsb_pkg::WORD_RESET;
            spareDef_reg  <= 16'h0000;
            loopDnDef_reg <= 16'h0000;
            sigEn_reg     <= rxlsb_pkg::WORD_RESET;
            mask_reg      <= rxlsb_pkg::WORD_RESET;
            manual_reg    <= 1'b0;
            stat3_reg     <= rxlsb_pkg::STAT_RESET;
            stat4_reg     <= rxlsb_pkg::STAT_RESET;
            hdlc_reg      <= rxlsb_pkg::STAT_RESET;
            stat7_reg     <= rxlsb_pkg::STAT_RESET;
            info_reg      <= rxlsb_pkg::STAT_RESET;
            irq_reg       <= 1'b0;
            prev_reg      <= 9'h000;
            spareM_reg    <= 1'b0;
            loopDnM_reg   <= 1'b0;
            rdmaCnt_reg   <= 2'h0;
            rxSync_reg    <= 3'h0;
            rxLvl_reg     <= 1'b0;
            lorcCnt_reg   <= 9'h000;
            secCnt_reg    <= '0;
            tmrCnt_reg    <= '0;
            mfCnt_reg     <= 13'h0000;
        end else begin
            wrPend_reg    <= wrPend_next;
            wrIdx_reg     <= wrIdx_next;
            rdata_reg     <= rdata_next;
            ready_reg     <= 1'b1;
            resp_reg      <= 1'b0;
            config_reg    <= config_next;
            spareDef_reg  <= spareDef_next;
            loopDnDef_reg <= loopDnDef_next;
            sigEn_reg     <= sigEn_next;
            mask_reg      <= mask_next;
            manual_reg    <= manual_next;
            stat3_reg     <= stat3_next;
            stat4_reg     <= stat4_next;
            hdlc_reg      <= hdlc_next;
            stat7_reg     <= stat7_next;
            info_reg      <= info_next;
            irq_reg       <= irq_next;
            prev_reg      <= prev_next;
            spareM_reg    <= spareM_next;
            loopDnM_reg   <= loopDnM_next;
            rdmaCnt_reg   <= rdmaCnt_next;
            rxSync_reg    <= rxSync_next;
            rxLvl_reg     <= rxLvl_next;
            lorcCnt_reg   <= lorcCnt_next;
            secCnt_reg    <= secCnt_next;
            tmrCnt_reg    <= tmrCnt_next;
            mfCnt_reg     <= mfCnt_next;
        end
    end

    assign hreadyout = ready_reg;
    assign hresp     = resp_reg;
    assign hrdata    = rdata_reg;
    assign rxIrqReq  = irq_reg;

endmodule // rxlsb_bank

// *** inc/rxlsb_pkg.sv ***
// Package: register map, field layout, timing counts and carriers of the rx latched status bank
package rxlsb_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_STAT3     = 12'h092;
    localparam logic [11:0] IDX_STAT4     = 12'h093;
    localparam logic [11:0] IDX_HDLC      = 12'h094;
    localparam logic [11:0] IDX_STAT7     = 12'h096;
    localparam logic [11:0] IDX_INFO      = 12'h09F;
    localparam logic [11:0] IDX_CONFIG    = 12'h0C0;
    localparam logic [11:0] IDX_SPARE_DEF = 12'h0C1;
    localparam logic [11:0] IDX_LOOPDN_DEF = 12'h0C2;
    localparam logic [11:0] IDX_SIG_EN    = 12'h0C3;
    localparam logic [11:0] IDX_MASK      = 12'h0C4;

    localparam logic [7:0]  STAT_RESET    = 8'h00;
    localparam logic [31:0] WORD_RESET    = 32'h0000_0000;

    // Config fields
    localparam int CFG_E1       = 0;
    localparam int CFG_ESF      = 1;
    localparam int CFG_CAS      = 2;
    localparam int CFG_SHORT    = 3;
    localparam int CFG_MANUAL   = 4;
    localparam int CFG_WM_LSB   = 8;
    localparam int WM_W         = 6;

    // Interrupt information bit positions
    localparam int INFO_STAT3   = 2;
    localparam int INFO_STAT4   = 3;
    localparam int INFO_HDLC    = 4;
    localparam int INFO_STAT7   = 6;

    // Mask byte lanes
    localparam int MASK_STAT3   = 0;
    localparam int MASK_STAT4   = 8;
    localparam int MASK_HDLC    = 16;
    localparam int MASK_STAT7   = 24;

    // Loss of receive clock: one channel time in core cycles, rounded up
    localparam int CORE_CLK_HZ  = 40_000_000;
    localparam int CHAN_T1_NS   = 5182;
    localparam int CHAN_E1_NS   = 3907;
    localparam int RX_CLOCK_LOSS_CONDITION_T1_CYC  = (CHAN_T1_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RX_CLOCK_LOSS_CONDITION_E1_CYC  = (CHAN_E1_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

    // Intervals counted in recovered clock edges
    localparam int RX_T1_HZ     = 1_544_000;
    localparam int RX_E1_HZ     = 2_048_000;
    localparam int ONE_SEC_MS   = 1000;
    localparam int SHORT_T1_MS  = 42;
    localparam int SHORT_E1_US  = 62500;
    localparam int E1_MF_US     = 2000;
    localparam int SEC_T1_EDGES = RX_T1_HZ / 1000 * ONE_SEC_MS;
    localparam int SEC_E1_EDGES = RX_E1_HZ / 1000 * ONE_SEC_MS;
    localparam int SHT_T1_EDGES = RX_T1_HZ / 1000 * SHORT_T1_MS;
    localparam int SHT_E1_EDGES = RX_E1_HZ / 1000 * SHORT_E1_US / 1000;
    localparam int MF_E1_EDGES  = RX_E1_HZ / 1000 * E1_MF_US / 1000;
    localparam int CNT_W        = 22;

    // Detector levels, same clock as the block
    typedef struct packed {
        logic        loopUp;
        logic        bocValid;
        logic        v52Link;
        logic        raiActive;
        logic        aisActive;
        logic        codeValid;
        logic [15:0] codeWord;
        logic [6:0]  hdlcFill;
    } rxlsb_level_s;

    // Single-cycle event strobes, same clock as the block
    typedef struct packed {
        logic        mfBoundary;
        logic        mfAlarmStrobe;
        logic        mfAlarmBit;
        logic        elasticFull;
        logic        elasticEmpty;
        logic [31:0] sigChange;
        logic        raiCiPattern;
        logic        aisCiPattern;
        logic        slcAlign;
        logic        dataLinkFull;
        logic        hdlcOverrun;
        logic        hdlcOpeningNext;
        logic        hdlcPacketEnd;
        logic        hdlcPacketStart;
    } rxlsb_event_s;

endpackage

// *** sim/rxlsb_bank_properties.sv ***
// Checker: bus and interrupt relations of the rx latched status bank
module rxlsb_bank_properties (
    input wire logic                    core_clk,
    input wire logic                    rstn,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [2:0]              hsize,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire logic [31:0]             hrdata,
    input wire logic                    recoveredRxClock,
    input wire rxlsb_pkg::rxlsb_level_s detLevel,
    input wire rxlsb_pkg::rxlsb_event_s detEvent,
    input wire logic                    rxIrqReq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        taken;
    logic [11:0] idx;
    logic [2:0]  quietCnt;
    logic        maskPend;
    logic [31:0] maskTrk;
    assign taken = hsel & htrans[1] & hready;
    assign idx = haddr[13:2];
    // Mask mirror; bus quiet time guards against writes still landing
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            quietCnt <= 3'h0;
            maskPend <= 1'b0;
            maskTrk <= 32'h0;
        end else begin
            quietCnt <= taken ? 3'h0 : quietCnt + {2'h0, quietCnt != 3'h7};
            maskPend <= taken & hwrite & (idx == rxlsb_pkg::IDX_MASK);
            if (maskPend) begin
                maskTrk <= hwdata;
            end
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    AST_RESET_QUIET: assert property ($rose(rstn) |-> hrdata == 32'h0 && !rxIrqReq)
        else $error("outputs not cleared by reset");
    AST_UPPER_ZERO: assert property (taken && !hwrite && idx[11:4] == 8'h09 |=> hrdata[31:8] == 24'h0)
        else $error("status read has upper bits set");
    AST_UNMAPPED_ZERO: assert property (taken && !hwrite && idx == 12'h095 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_FULL_TO_IRQ: assert property (detEvent.elasticFull && maskTrk[15] && quietCnt > 3'h2 |-> ##3 rxIrqReq)
        else $error("enabled full event gave no request");
    AST_IRQ_HOLDS: assert property ($past(rxIrqReq) && quietCnt == 3'h7 |-> rxIrqReq)
        else $error("request dropped without host action");
    AST_MASKED_QUIET: assert property (maskTrk == 32'h0 && quietCnt == 3'h7 |-> !rxIrqReq)
        else $error("request raised with all masked");
    AST_IRQ_CAUSE: assert property ($rose(rxIrqReq) |-> maskTrk != 32'h0)
        else $error("request rose with mask clear");
    cover property (detEvent.elasticFull ##3 rxIrqReq);
    cover property ($fell(rxIrqReq));
    cover property (taken && !hwrite && idx == rxlsb_pkg::IDX_HDLC);
endmodule // rxlsb_bank_properties

bind rxlsb_bank rxlsb_bank_properties u_rxlsb_bank_properties (
    .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .recoveredRxClock(recoveredRxClock),
    .detLevel(detLevel), .detEvent(detEvent), .rxIrqReq(rxIrqReq));

// *** sim/rx_latched_status_bank_tb_top.sv ***
// Testbench: random and corner-case run of the rx latched status bank
module rx_latched_status_bank_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rstn, hsel, hwrite, hreadyout, hresp, recoveredRxClock, rxIrqReq;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] spareDef;
    rxlsb_pkg::rxlsb_level_s lvl, nl;
    rxlsb_pkg::rxlsb_event_s evt, ne;
    int failCount, nCompared, seed, k;
    // Short interval counts keep timer tests brief
    rxlsb_bank #(.SEC_T1(20), .SEC_E1(16), .SHT_T1(8), .SHT_E1(8)) u_rxlsb_bank (
        .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .recoveredRxClock(recoveredRxClock), .detLevel(lvl), .detEvent(evt), .rxIrqReq(rxIrqReq));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic stopTest;
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic waitReady;
        for (int n = 0; n < 64; n++) begin
            @(posedge core_clk);
            if (hreadyout === 1'b1) return;
        end
        failCount++;
        stopTest();
    endtask
    task automatic xfer(input logic [11:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'h0};
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rdv = hrdata;
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [7:0] msk, input logic [7:0] exp);
        xfer(idx, 1'b0, 32'h0);
        chk(rdv & {24'hFFFFFF, msk}, {24'h0, exp});
    endtask
    task automatic fire;
        @(posedge core_clk);
        evt <= ne;
        ne = '0;
        @(posedge core_clk);
        evt <= '0;
    endtask
    task automatic setLvl;
        @(posedge core_clk);
        lvl <= nl;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (2) @(posedge core_clk);
            recoveredRxClock <= ~recoveredRxClock;
        end
        // Let the three-stage sampler settle
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        #(25ns * 40000);
        failCount++;
        stopTest();
    end
    initial begin
        seed = 32'h6004ED09;
        {rstn, hsel, hwrite, recoveredRxClock, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        {lvl, nl, evt, ne} = '0;
        {failCount, nCompared} = '0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        for (k = 0; k < 8; k++) rdc(12'h092 + k[11:0], 8'hFF, 8'h00);
        rdc(rxlsb_pkg::IDX_INFO, 8'hFF, 8'h00);
        $display("reset values done");
        repeat (230) @(posedge core_clk);
        rdc(rxlsb_pkg::IDX_STAT3, 8'hFF, 8'h08);
        toggle(60);
        rdc(rxlsb_pkg::IDX_STAT3, 8'hFF, 8'h88);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h06, 8'h06);
        xfer(rxlsb_pkg::IDX_STAT3, 1'b1, 32'hFF);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        rdc(rxlsb_pkg::IDX_STAT3, 8'hFF, 8'h00);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h06, 8'h00);
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h10);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h02, 8'h02);
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h8);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        toggle(6);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h06, 8'h02);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        toggle(12);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h06, 8'h02);
        $display("clock and timer done");
        spareDef = 16'($random(seed));
        xfer(rxlsb_pkg::IDX_SPARE_DEF, 1'b1, {16'h0, spareDef});
        xfer(rxlsb_pkg::IDX_LOOPDN_DEF, 1'b1, {16'h0, spareDef ^ 16'h00FF});
        nl.codeValid = 1'b1;
        nl.codeWord = spareDef ^ 16'h0F00;
        setLvl();
        rdc(rxlsb_pkg::IDX_STAT3, 8'h77, 8'h00);
        nl.codeWord = spareDef;
        setLvl();
        nl.codeWord = spareDef ^ 16'h00FF;
        nl.loopUp = 1'b1;
        setLvl();
        rdc(rxlsb_pkg::IDX_STAT3, 8'h77, 8'h47);
        nl.codeWord = spareDef ^ 16'h0F00;
        nl.loopUp = 1'b0;
        setLvl();
        rdc(rxlsb_pkg::IDX_STAT3, 8'h77, 8'h77);
        xfer(rxlsb_pkg::IDX_STAT3, 1'b1, 32'hFF);
        $display("code detect done");
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h5);
        ne.mfAlarmStrobe = 1'b1;
        ne.mfAlarmBit = 1'b1;
        fire();
        ne.mfAlarmStrobe = 1'b1;
        fire();
        rdc(rxlsb_pkg::IDX_STAT3, 8'h77, 8'h00);
        for (k = 0; k < 3; k++) begin
            ne.mfAlarmStrobe = 1'b1;
            ne.mfAlarmBit = k < 2;
            ne.mfBoundary = 1'b1;
            fire();
        end
        nl.v52Link = 1'b1;
        setLvl();
        nl.v52Link = 1'b0;
        setLvl();
        rdc(rxlsb_pkg::IDX_STAT3, 8'h77, 8'h33);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h01, 8'h01);
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h1);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        toggle(8192);
        rdc(rxlsb_pkg::IDX_STAT4, 8'h01, 8'h01);
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h0A00);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        $display("e1 alarms done");
        k = {$random(seed)} % 32;
        xfer(rxlsb_pkg::IDX_SIG_EN, 1'b1, 32'h1 << k);
        ne.sigChange = ~(32'h1 << k);
        fire();
        rdc(rxlsb_pkg::IDX_STAT4, 8'hE9, 8'h00);
        ne.elasticFull = 1'b1;
        ne.sigChange = 32'h1 << k;
        fire();
        rdc(rxlsb_pkg::IDX_STAT4, 8'hE9, 8'hA8);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'h20);
        rdc(rxlsb_pkg::IDX_STAT4, 8'hE9, 8'h88);
        ne.elasticEmpty = 1'b1;
        ne.mfBoundary = 1'b1;
        fire();
        rdc(rxlsb_pkg::IDX_STAT4, 8'hE9, 8'hE9);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        $display("elastic and signaling done");
        nl.hdlcFill = 7'h0A;
        setLvl();
        rdc(rxlsb_pkg::IDX_HDLC, 8'hFF, 8'h01);
        rdc(rxlsb_pkg::IDX_HDLC, 8'hFF, 8'h00);
        nl.hdlcFill = 7'h0B;
        setLvl();
        ne.hdlcOverrun = 1'b1;
        ne.hdlcOpeningNext = 1'b1;
        ne.hdlcPacketEnd = 1'b1;
        ne.hdlcPacketStart = 1'b1;
        fire();
        rdc(rxlsb_pkg::IDX_HDLC, 8'hFF, 8'h3E);
        rdc(rxlsb_pkg::IDX_HDLC, 8'hFF, 8'h00);
        $display("hdlc done");
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h2);
        {ne.raiCiPattern, ne.aisCiPattern} = 2'h3;
        fire();
        rdc(rxlsb_pkg::IDX_STAT7, 8'hFF, 8'h00);
        {nl.raiActive, nl.aisActive, nl.bocValid} = 3'h7;
        setLvl();
        nl.bocValid = 1'b0;
        setLvl();
        {ne.raiCiPattern, ne.aisCiPattern, ne.slcAlign, ne.dataLinkFull} = 4'hF;
        fire();
        rdc(rxlsb_pkg::IDX_STAT7, 8'hFF, 8'h3F);
        xfer(rxlsb_pkg::IDX_CONFIG, 1'b1, 32'h0);
        {ne.raiCiPattern, ne.aisCiPattern} = 2'h3;
        fire();
        rdc(rxlsb_pkg::IDX_STAT7, 8'hFF, 8'h10);
        $display("t1 code status done");
        xfer(rxlsb_pkg::IDX_MASK, 1'b1, 32'h0000FF00);
        repeat (3) @(posedge core_clk);
        ne.elasticFull = 1'b1;
        fire();
        repeat (10) @(posedge core_clk);
        chk({31'h0, rxIrqReq}, 32'h1);
        rdc(rxlsb_pkg::IDX_INFO, 8'hFF, 8'h08);
        xfer(rxlsb_pkg::IDX_STAT4, 1'b1, 32'hFF);
        repeat (4) @(posedge core_clk);
        chk({31'h0, rxIrqReq}, 32'h0);
        rdc(rxlsb_pkg::IDX_INFO, 8'hFF, 8'h00);
        $display("interrupt done");
        stopTest();
    end
endmodule // rx_latched_status_bank_tb_top
